// ==== verilog/dma_ctrl_regs.vh ====
// Register indices, field positions, reset values for the DMA pointer block
`ifndef DMA_CTRL_REGS_VH
`define DMA_CTRL_REGS_VH

// Controller register indices (byte address is four times the index)
`define IDX_CTRL 6'h00
`define IDX_IRQ_MASK 6'h01
`define IDX_IRQ_FLAGS 6'h03
`define IDX_STATE 6'h04
`define IDX_TEMP_LO 6'h06
`define IDX_TEMP_HI 6'h07
`define IDX_CH0_BASE 6'h10
`define IDX_CH1_BASE 6'h20
`define IDX_RSVD_BASE 6'h30

// Channel register offsets within a channel block
`define CH_CTRLA 4'h0
`define CH_ADDR_CTRL 4'h2
`define CH_CNT_LO 4'h4
`define CH_CNT_HI 4'h5
`define CH_BLOCK_REPEAT_COUNTER 4'h6
`define CH_SRC0 4'h8
`define CH_SRC1 4'h9
`define CH_SRC2 4'ha
`define CH_DST0 4'hc
`define CH_DST1 4'hd
`define CH_DST2 4'he

// Field positions
`define CTRL_ENABLE_BIT 7
`define CTRLA_ENABLE_BIT 7
`define CTRLA_REPEAT_BIT 5
`define SRC_MODE_LSB 4
`define DST_MODE_LSB 0
`define FLAG_DONE0_BIT 0
`define FLAG_ERR0_BIT 4
`define STATE_WAIT0_BIT 0
`define STATE_ACTIVE0_BIT 4
`define FLAG_MASK 8'h33

// Step mode codes
`define STEP_FIXED 2'b00
`define STEP_INC 2'b01
`define STEP_DEC 2'b10

// Reset values
`define RST_BYTE 8'h00
`define RST_CNT 16'h0001
`define RST_BLOCK_REPEAT_COUNTER 8'h00
`define RST_PTR 24'h000000

// Bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== verilog/dma_chan_ptr.v ====
// Per-channel byte count, repeat counter and address pointers
`timescale 1ns/1ns

module dma_chan_ptr (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    input wire ce,
    // Configuration
    input wire run,
    input wire repeat_mode,
    input wire [1:0] src_mode,
    input wire [1:0] dst_mode,
    // Transfer progress
    input wire byte_read,
    input wire byte_written,
    // Software loads
    input wire cnt_load,
    input wire [15:0] cnt_val,
    input wire rep_load,
    input wire [7:0] rep_val,
    input wire src_load,
    input wire dst_load,
    input wire [23:0] ptr_val,
    // State
    output reg [23:0] src_ptr_ff,
    output reg [23:0] dst_ptr_ff,
    output reg [15:0] count_ff,
    output reg [7:0] block_repeat_counter_ff,
    output reg block_done_ff,
    output reg trans_done_ff
);

`include "dma_ctrl_regs.vh"

reg [15:0] reload_ff;
wire last_byte;

assign last_byte = run & byte_read & ~cnt_load & (count_ff == 16'h0001);

function [23:0] step;
    input [23:0] ptr;
    input [1:0] mode;
    begin
        case (mode)
            `STEP_INC: step = ptr + 24'h000001;
            `STEP_DEC: step = ptr - 24'h000001;
            // Reserved code behaves as fixed so a bad setting cannot run away
            default: step = ptr;
        endcase
    end
endfunction

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        src_ptr_ff <= `RST_PTR;
        dst_ptr_ff <= `RST_PTR;
        count_ff <= `RST_CNT;
        reload_ff <= `RST_CNT;
        block_repeat_counter_ff <= `RST_BLOCK_REPEAT_COUNTER;
        block_done_ff <= 1'b0;
        trans_done_ff <= 1'b0;
    end else if (ce) begin
        if (cnt_load) begin
            count_ff <= cnt_val;
            reload_ff <= cnt_val;
        end else if (run && byte_read) begin
            if (last_byte) begin
                count_ff <= reload_ff;
            end else begin
                count_ff <= count_ff - 16'h0001;
            end
        end
        if (rep_load) begin
            block_repeat_counter_ff <= rep_val;
        end else if (last_byte && block_repeat_counter_ff != 8'h00) begin
            block_repeat_counter_ff <= block_repeat_counter_ff - 8'h01;
        end
        block_done_ff <= last_byte;
        // Zero repeat count in repeat mode never ends the transaction
        trans_done_ff <= last_byte &
            (~repeat_mode | (block_repeat_counter_ff == 8'h01));
        if (src_load) begin
            src_ptr_ff <= ptr_val;
        end else if (run && byte_read) begin
            src_ptr_ff <= step(src_ptr_ff, src_mode);
        end
        if (dst_load) begin
            dst_ptr_ff <= ptr_val;
        end else if (run && byte_written) begin
            dst_ptr_ff <= step(dst_ptr_ff, dst_mode);
        end
    end
end

endmodule // dma_chan_ptr

// ==== verilog/dma_ptr_ctrl.v ====
// Two-channel DMA pointer and repeat block with AXI4-Lite registers
`timescale 1ns/1ns

module dma_ptr_ctrl (
    // Clock, reset, enable
    input wire CORE_CLK,
    input wire RST_N,
    input wire CLK_EN,
    // AXI4-Lite write address and data
    input wire AWVALID,
    output wire AWREADY,
    input wire [7:0] AWADDR,
    input wire [2:0] AWPROT,
    input wire WVALID,
    output wire WREADY,
    input wire [31:0] WDATA,
    input wire [3:0] WSTRB,
    // AXI4-Lite write response
    output wire BVALID,
    input wire BREADY,
    output wire [1:0] BRESP,
    // AXI4-Lite read
    input wire ARVALID,
    output wire ARREADY,
    input wire [7:0] ARADDR,
    input wire [2:0] ARPROT,
    output wire RVALID,
    input wire RREADY,
    output wire [31:0] RDATA,
    output wire [1:0] RRESP,
    // Channel progress from the transfer engine
    input wire [1:0] BYTE_READ,
    input wire [1:0] BYTE_WRITTEN,
    input wire [1:0] BUS_ERR,
    input wire [1:0] TRIGGER_REQ,
    // Channel state
    output wire [23:0] CH0_SRC_PTR,
    output wire [23:0] CH0_DST_PTR,
    output wire [23:0] CH1_SRC_PTR,
    output wire [23:0] CH1_DST_PTR,
    output wire [1:0] CH_ACTIVE,
    output wire [1:0] BLOCK_DONE,
    // Interrupt
    output wire IRQ
);

`include "dma_ctrl_regs.vh"

// Bus slave state
reg awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
reg aw_full_ff, w_full_ff;
reg [5:0] aw_idx_ff;
reg [7:0] w_byte_ff;
reg w_lane_ff;
reg [1:0] bresp_ff, rresp_ff;
reg [7:0] rdata_ff;

// Controller registers
reg [7:0] ctrl_ff, mask_ff, flags_ff, temp_lo_ff, temp_hi_ff;
reg irq_ff;
reg [7:0] nxt_flags;

// Per-channel state gathered from the generate loop
wire [47:0] src_all, dst_all;
wire [31:0] cnt_all;
wire [15:0] rep_all, ctrla_all, addr_ctrl_all;
wire [1:0] active, blk_done, trn_done;

wire do_write;
wire wr_en;
wire ar_take;
wire wr_ok;
wire rd_ok;
wire [3:0] wr_off;
wire [3:0] rd_off;
wire [5:0] rd_idx;
reg [7:0] rd_byte;
reg [2:0] rd_ch;

assign do_write = aw_full_ff & w_full_ff & ~bvalid_ff;
assign wr_ok = idx_mapped(aw_idx_ff);
assign wr_en = do_write & w_lane_ff & wr_ok;
assign wr_off = aw_idx_ff[3:0];
assign ar_take = ARVALID & arready_ff;
assign rd_idx = ARADDR[7:2];
assign rd_off = rd_idx[3:0];
assign rd_ok = idx_mapped(rd_idx);

function idx_mapped;
    input [5:0] idx;
    begin
        if (idx[5:4] == 2'b00) begin
            case (idx[3:0])
                4'h0, 4'h1, 4'h3, 4'h4, 4'h6, 4'h7: idx_mapped = 1'b1;
                default: idx_mapped = 1'b0;
            endcase
        end else if (idx < `IDX_RSVD_BASE) begin
            case (idx[3:0])
                `CH_CTRLA, `CH_ADDR_CTRL, `CH_CNT_LO, `CH_CNT_HI,
                `CH_BLOCK_REPEAT_COUNTER, `CH_SRC0, `CH_SRC1, `CH_SRC2,
                `CH_DST0, `CH_DST1, `CH_DST2: idx_mapped = 1'b1;
                default: idx_mapped = 1'b0;
            endcase
        end else begin
            idx_mapped = 1'b0;
        end
    end
endfunction

// Write: address and data taken in either order, answer two cycles after both
always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
        aw_full_ff <= 1'b0;
        w_full_ff <= 1'b0;
        bvalid_ff <= 1'b0;
        bresp_ff <= `RESP_OKAY;
        aw_idx_ff <= 6'h00;
        w_byte_ff <= 8'h00;
        w_lane_ff <= 1'b0;
    end else if (CLK_EN) begin
        if (AWVALID && awready_ff) begin
            aw_full_ff <= 1'b1;
            awready_ff <= 1'b0;
            aw_idx_ff <= AWADDR[7:2];
        end
        if (WVALID && wready_ff) begin
            w_full_ff <= 1'b1;
            wready_ff <= 1'b0;
            w_byte_ff <= WDATA[7:0];
            w_lane_ff <= WSTRB[0];
        end
        if (do_write) begin
            aw_full_ff <= 1'b0;
            w_full_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bvalid_ff && BREADY) begin
            bvalid_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
        end
    end
end

// Channel-level write strobes
wire [1:0] wr_ch;
assign wr_ch[0] = wr_en & (aw_idx_ff[5:4] == `IDX_CH0_BASE >> 4);
assign wr_ch[1] = wr_en & (aw_idx_ff[5:4] == `IDX_CH1_BASE >> 4);
wire wr_ctl = wr_en & (aw_idx_ff[5:4] == 2'b00);
wire [23:0] ptr_val = {w_byte_ff, temp_hi_ff, temp_lo_ff};
wire [15:0] cnt_val = {w_byte_ff, temp_lo_ff};

genvar g;
generate
    for (g = 0; g < 2; g = g + 1) begin : chan
        reg [7:0] ctrla_ff;
        reg [7:0] addr_ctrl_ff;
        wire run;
        wire wr_here;
        assign wr_here = wr_ch[g];
        assign run = ctrla_ff[`CTRLA_ENABLE_BIT] & ctrl_ff[`CTRL_ENABLE_BIT];
        assign ctrla_all[8*g +: 8] = ctrla_ff;
        assign addr_ctrl_all[8*g +: 8] = addr_ctrl_ff;
        assign active[g] = ctrla_ff[`CTRLA_ENABLE_BIT];

        always @(posedge CORE_CLK or negedge RST_N) begin
            if (!RST_N) begin
                ctrla_ff <= `RST_BYTE;
                addr_ctrl_ff <= `RST_BYTE;
            end else if (CLK_EN) begin
                // A fresh software start wins over an ending transaction
                if (wr_here && wr_off == `CH_CTRLA) begin
                    ctrla_ff <= w_byte_ff;
                end else if (trn_done[g] || BUS_ERR[g]) begin
                    ctrla_ff[`CTRLA_ENABLE_BIT] <= 1'b0;
                end
                if (wr_here && wr_off == `CH_ADDR_CTRL &&
                        !ctrla_ff[`CTRLA_ENABLE_BIT]) begin
                    addr_ctrl_ff <= w_byte_ff;
                end
            end
        end

        dma_chan_ptr u_ptr (
            .clk(CORE_CLK),
            .rst_n(RST_N),
            .ce(CLK_EN),
            .run(run),
            .repeat_mode(ctrla_ff[`CTRLA_REPEAT_BIT]),
            .src_mode(addr_ctrl_ff[`SRC_MODE_LSB +: 2]),
            .dst_mode(addr_ctrl_ff[`DST_MODE_LSB +: 2]),
            .byte_read(BYTE_READ[g]),
            .byte_written(BYTE_WRITTEN[g]),
            .cnt_load(wr_here && wr_off == `CH_CNT_HI),
            .cnt_val(cnt_val),
            .rep_load(wr_here && wr_off == `CH_BLOCK_REPEAT_COUNTER),
            .rep_val(w_byte_ff),
            .src_load(wr_here && wr_off == `CH_SRC2),
            .dst_load(wr_here && wr_off == `CH_DST2),
            .ptr_val(ptr_val),
            .src_ptr_ff(src_all[24*g +: 24]),
            .dst_ptr_ff(dst_all[24*g +: 24]),
            .count_ff(cnt_all[16*g +: 16]),
            .block_repeat_counter_ff(rep_all[8*g +: 8]),
            .block_done_ff(blk_done[g]),
            .trans_done_ff(trn_done[g])
        );
    end
endgenerate

// Read data selection
always @* begin
    rd_ch = 3'd0;
    rd_byte = 8'h00;
    if (rd_idx[5:4] == `IDX_CH1_BASE >> 4) begin
        rd_ch = 3'd1;
    end
    if (rd_idx[5:4] == 2'b00) begin
        case (rd_off)
            4'h0: rd_byte = ctrl_ff;
            4'h1: rd_byte = mask_ff;
            4'h3: rd_byte = flags_ff;
            4'h4: rd_byte = {2'b00, active, 2'b00, active & TRIGGER_REQ};
            4'h6: rd_byte = temp_lo_ff;
            4'h7: rd_byte = temp_hi_ff;
            default: rd_byte = 8'h00;
        endcase
    end else if (rd_ok) begin
        case (rd_off)
            `CH_CTRLA: rd_byte = ctrla_all[8*rd_ch +: 8];
            `CH_ADDR_CTRL: rd_byte = addr_ctrl_all[8*rd_ch +: 8];
            `CH_CNT_LO: rd_byte = cnt_all[16*rd_ch +: 8];
            `CH_BLOCK_REPEAT_COUNTER: rd_byte = rep_all[8*rd_ch +: 8];
            `CH_SRC0: rd_byte = src_all[24*rd_ch +: 8];
            `CH_DST0: rd_byte = dst_all[24*rd_ch +: 8];
            // Upper bytes come from staging, latched by the low-byte read
            `CH_CNT_HI, `CH_SRC1, `CH_DST1: rd_byte = temp_lo_ff;
            `CH_SRC2, `CH_DST2: rd_byte = temp_hi_ff;
            default: rd_byte = 8'h00;
        endcase
    end
end

// Read channel: answer one cycle after the address is taken
always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
        arready_ff <= 1'b1;
        rvalid_ff <= 1'b0;
        rdata_ff <= 8'h00;
        rresp_ff <= `RESP_OKAY;
    end else if (CLK_EN) begin
        if (ar_take) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_byte;
            rresp_ff <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_ff && RREADY) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end
end

// Staging registers shared by all multi-byte registers
always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
        temp_lo_ff <= `RST_BYTE;
        temp_hi_ff <= `RST_BYTE;
    end else if (CLK_EN) begin
        // Writes take priority over a read latch of the same staging byte in that cycle
        if (wr_ctl && wr_off == `IDX_TEMP_LO) begin
            temp_lo_ff <= w_byte_ff;
        end else if (wr_ch != 2'b00 && (wr_off == `CH_SRC0 ||
                wr_off == `CH_DST0 || wr_off == `CH_CNT_LO)) begin
            temp_lo_ff <= w_byte_ff;
        end else if (ar_take && rd_ok && rd_idx[5:4] != 2'b00) begin
            if (rd_off == `CH_SRC0) begin
                temp_lo_ff <= src_all[24*rd_ch + 8 +: 8];
                temp_hi_ff <= src_all[24*rd_ch + 16 +: 8];
            end else if (rd_off == `CH_DST0) begin
                temp_lo_ff <= dst_all[24*rd_ch + 8 +: 8];
                temp_hi_ff <= dst_all[24*rd_ch + 16 +: 8];
            end else if (rd_off == `CH_CNT_LO) begin
                temp_lo_ff <= cnt_all[16*rd_ch + 8 +: 8];
            end
        end
        if (wr_ctl && wr_off == `IDX_TEMP_HI) begin
            temp_hi_ff <= w_byte_ff;
        end else if (wr_ch != 2'b00 && (wr_off == `CH_SRC1 ||
                wr_off == `CH_DST1)) begin
            temp_hi_ff <= w_byte_ff;
        end
    end
end

// Controller control, mask, sticky flags and interrupt
always @* begin
    nxt_flags = flags_ff;
    if (wr_ctl && wr_off == `IDX_IRQ_FLAGS) begin
        nxt_flags = flags_ff & ~w_byte_ff;
    end
    // Hardware events win over a clear in the same cycle
    nxt_flags = nxt_flags | {2'b00, BUS_ERR & active, 2'b00, trn_done};
    nxt_flags = nxt_flags & `FLAG_MASK;
end

always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
        ctrl_ff <= `RST_BYTE;
        mask_ff <= `RST_BYTE;
        flags_ff <= `RST_BYTE;
        irq_ff <= 1'b0;
    end else if (CLK_EN) begin
        if (wr_ctl && wr_off == `IDX_CTRL) begin
            ctrl_ff <= w_byte_ff;
        end
        if (wr_ctl && wr_off == `IDX_IRQ_MASK) begin
            mask_ff <= w_byte_ff & `FLAG_MASK;
        end
        flags_ff <= nxt_flags;
        irq_ff <= |(nxt_flags & mask_ff);
    end
end

assign AWREADY = awready_ff;
assign WREADY = wready_ff;
assign BVALID = bvalid_ff;
assign BRESP = bresp_ff;
assign ARREADY = arready_ff;
assign RVALID = rvalid_ff;
assign RDATA = {24'h000000, rdata_ff};
assign RRESP = rresp_ff;
assign CH0_SRC_PTR = src_all[23:0];
assign CH1_SRC_PTR = src_all[47:24];
assign CH0_DST_PTR = dst_all[23:0];
assign CH1_DST_PTR = dst_all[47:24];
assign CH_ACTIVE = active;
assign BLOCK_DONE = blk_done;
assign IRQ = irq_ff;

endmodule // dma_ptr_ctrl

// ==== tb/xfer_partner.sv ====
// Transfer engine model: one read then one write pulse per byte
`timescale 1ns/1ns

module xfer_partner (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Channel state and pacing
    input wire [1:0] active,
    input wire slow,
    // Progress pulses
    output reg [1:0] byte_read,
    output reg [1:0] byte_written
);
    reg [2:0] gap_ff [0:1];
    integer c;

    // Reads are spaced so a channel that ends sees no stray read
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            byte_read <= 2'h0;
            byte_written <= 2'h0;
            gap_ff[0] <= 3'h0;
            gap_ff[1] <= 3'h0;
        end else begin
            for (c = 0; c < 2; c = c + 1) begin
                byte_written[c] <= byte_read[c];
                byte_read[c] <= 1'h0;
                if (gap_ff[c] != 3'h0) begin
                    gap_ff[c] <= gap_ff[c] - 3'h1;
                end else if (active[c] && !byte_read[c]
                             && !byte_written[c]) begin
                    byte_read[c] <= 1'h1;
                    gap_ff[c] <= slow ? 3'h4 : 3'h1;
                end
            end
        end
    end
endmodule // xfer_partner

// ==== tb/dma_ptr_ctrl_asserts.sv ====
// Concurrent checks on the ports of the DMA pointer block
`timescale 1ns/1ns

module dma_ptr_ctrl_asserts (
    // Clock and reset
    input wire CORE_CLK,
    input wire RST_N,
    input wire CLK_EN,
    // Bus handshakes
    input wire AWVALID,
    input wire AWREADY,
    input wire WVALID,
    input wire WREADY,
    input wire BVALID,
    input wire BREADY,
    input wire [1:0] BRESP,
    input wire ARVALID,
    input wire ARREADY,
    input wire RVALID,
    input wire RREADY,
    input wire [31:0] RDATA,
    // Channel progress and state
    input wire [1:0] BYTE_READ,
    input wire [1:0] BYTE_WRITTEN,
    input wire [1:0] BUS_ERR,
    input wire [23:0] CH0_SRC_PTR,
    input wire [23:0] CH0_DST_PTR,
    input wire [1:0] CH_ACTIVE,
    input wire [1:0] BLOCK_DONE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    a_done_after_read: assert property
        (BLOCK_DONE[0] |-> $past(BYTE_READ[0]))
        else $error("block end without a read");
    a_src_cause: assert property
        ($changed(CH0_SRC_PTR) |-> $past(BYTE_READ[0]) || $rose(BVALID))
        else $error("source pointer moved without cause");
    a_src_step: assert property
        ($changed(CH0_SRC_PTR) && !$rose(BVALID) |->
         CH0_SRC_PTR - $past(CH0_SRC_PTR) == 24'h1 ||
         $past(CH0_SRC_PTR) - CH0_SRC_PTR == 24'h1)
        else $error("source step not one byte");
    a_dst_cause: assert property
        ($changed(CH0_DST_PTR) |-> $past(BYTE_WRITTEN[0]) || $rose(BVALID))
        else $error("destination pointer moved without cause");
    a_dst_step: assert property
        ($changed(CH0_DST_PTR) && !$rose(BVALID) |->
         CH0_DST_PTR - $past(CH0_DST_PTR) == 24'h1 ||
         $past(CH0_DST_PTR) - CH0_DST_PTR == 24'h1)
        else $error("destination step not one byte");
    a_end_cause: assert property
        ($fell(CH_ACTIVE[0]) |-> $past(BYTE_READ[0]) ||
         $past(BYTE_READ[0], 2) || $past(BUS_ERR[0]) ||
         $past(BUS_ERR[0], 2) || $rose(BVALID))
        else $error("channel stopped without cause");
    a_start_by_write: assert property
        ($rose(CH_ACTIVE[1]) |-> $rose(BVALID))
        else $error("channel started without a write");
    a_bresp_hold: assert property
        (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped early");
    a_read_answer: assert property
        (ARVALID && ARREADY && CLK_EN |=> RVALID)
        else $error("read answer late");
    a_write_answer: assert property
        (AWVALID && AWREADY && WVALID && WREADY && CLK_EN |-> ##2 BVALID)
        else $error("write answer late");
    a_rdata_upper: assert property
        (RVALID |-> RDATA[31:8] == 24'h0)
        else $error("read data upper bits set");
endmodule // dma_ptr_ctrl_asserts

bind dma_ptr_ctrl dma_ptr_ctrl_asserts chk (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
    .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID),
    .RREADY(RREADY), .RDATA(RDATA), .BYTE_READ(BYTE_READ),
    .BYTE_WRITTEN(BYTE_WRITTEN), .BUS_ERR(BUS_ERR),
    .CH0_SRC_PTR(CH0_SRC_PTR), .CH0_DST_PTR(CH0_DST_PTR),
    .CH_ACTIVE(CH_ACTIVE), .BLOCK_DONE(BLOCK_DONE)
);

// ==== tb/test_dma_channel_address_repeat.sv ====
// Self-checking bench for the DMA pointer and repeat block
`timescale 1ns/1ns

module test_dma_channel_address_repeat;
    reg CORE_CLK = 1'h0;
    reg RST_N = 1'h0;
    reg AWVALID = 1'h0;
    reg [7:0] AWADDR = 8'h0;
    reg WVALID = 1'h0;
    reg [31:0] WDATA = 32'h0;
    reg BREADY = 1'h0;
    reg ARVALID = 1'h0;
    reg [7:0] ARADDR = 8'h0;
    reg RREADY = 1'h0;
    reg [1:0] BUS_ERR = 2'h0;
    reg [1:0] TRIGGER_REQ = 2'h0;
    reg slow = 1'h0;
    wire AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
    wire [1:0] BRESP, RRESP, BYTE_READ, BYTE_WRITTEN, CH_ACTIVE, BLOCK_DONE;
    wire [31:0] RDATA;
    wire [23:0] s0, d0, s1, d1;
    integer num_errors = 0, cmp_count = 0, seed = 95, nrd = 0, nblk = 0;
    integer m, nb, rp, b0, r0, n;
    reg [23:0] sa, da;
    reg [1:0] md;

    always #20 CORE_CLK = ~CORE_CLK;

    dma_ptr_ctrl uut (
        .CORE_CLK(CORE_CLK), .RST_N(RST_N), .CLK_EN(1'h1),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
        .AWPROT(3'h0), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA),
        .WSTRB(4'hf), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
        .ARPROT(3'h0), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
        .RRESP(RRESP), .BYTE_READ(BYTE_READ), .BYTE_WRITTEN(BYTE_WRITTEN),
        .BUS_ERR(BUS_ERR), .TRIGGER_REQ(TRIGGER_REQ), .CH0_SRC_PTR(s0),
        .CH0_DST_PTR(d0), .CH1_SRC_PTR(s1), .CH1_DST_PTR(d1),
        .CH_ACTIVE(CH_ACTIVE), .BLOCK_DONE(BLOCK_DONE), .IRQ(IRQ)
    );

    xfer_partner far (
        .clk(CORE_CLK), .rst_n(RST_N), .active(CH_ACTIVE), .slow(slow),
        .byte_read(BYTE_READ), .byte_written(BYTE_WRITTEN)
    );

    // A read only counts while the channel runs at that edge
    always @(posedge CORE_CLK) begin
        if (BYTE_READ[0] && CH_ACTIVE[0]) nrd <= nrd + 1;
        if (BLOCK_DONE[0]) nblk <= nblk + 1;
    end

    task test_done;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
            if (num_errors == 0 && cmp_count > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    task chk(input [31:0] seen, input [31:0] exp, input string what);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("unexpected %0s: expected %h, seen %h",
                         what, exp, seen);
            end
        end
    endtask

    task hang(input string what);
        begin
            num_errors = num_errors + 1;
            $display("unexpected %0s: expected answer, seen none", what);
            test_done;
        end
    endtask

    task wr(input [5:0] idx, input [7:0] d, input [1:0] er);
        reg got;
        begin
            @(posedge CORE_CLK);
            AWADDR <= {idx, 2'h0};
            WDATA <= {24'h0, d};
            AWVALID <= 1'h1;
            WVALID <= 1'h1;
            // Even registers hold off the response so BVALID must wait
            BREADY <= idx[0];
            got = 1'h0;
            for (n = 0; n < 50 && !got; n = n + 1) begin
                @(posedge CORE_CLK);
                if (AWREADY) AWVALID <= 1'h0;
                if (WREADY) WVALID <= 1'h0;
                if (BVALID && !BREADY) BREADY <= 1'h1;
                if (BVALID && BREADY) begin
                    got = 1'h1;
                    BREADY <= 1'h0;
                    chk(BRESP, er, "write response");
                end
            end
            if (!got) hang("write");
        end
    endtask

    task rd(input [5:0] idx, input [7:0] d, input [1:0] er, input string nm);
        reg got;
        begin
            @(posedge CORE_CLK);
            ARADDR <= {idx, 2'h0};
            ARVALID <= 1'h1;
            RREADY <= 1'h1;
            got = 1'h0;
            for (n = 0; n < 50 && !got; n = n + 1) begin
                @(posedge CORE_CLK);
                if (ARREADY) ARVALID <= 1'h0;
                if (RVALID) begin
                    got = 1'h1;
                    RREADY <= 1'h0;
                    chk(RDATA, {24'h0, d}, nm);
                    chk(RRESP, er, nm);
                end
            end
            if (!got) hang("read");
        end
    endtask

    function [23:0] live(input [5:0] idx);
        case (idx)
            6'h18: live = s0;
            6'h1c: live = d0;
            6'h28: live = s1;
            default: live = d1;
        endcase
    endfunction

    function [23:0] moved(input [23:0] p, input [1:0] md, input [23:0] k);
        case (md)
            2'h1: moved = p + k;
            2'h2: moved = p - k;
            default: moved = p;
        endcase
    endfunction

    // Low bytes must not reach the live pointer before the top byte
    task wrp(input [5:0] idx, input [23:0] v);
        reg [23:0] old;
        begin
            old = live(idx);
            wr(idx, v[7:0], 2'h0);
            wr(idx + 6'h1, v[15:8], 2'h0);
            chk(live(idx), old, "staged pointer");
            wr(idx + 6'h2, v[23:16], 2'h0);
            chk(live(idx), v, "pointer commit");
            rd(idx, v[7:0], 2'h0, "pointer byte0");
            rd(idx + 6'h1, v[15:8], 2'h0, "pointer byte1");
            rd(idx + 6'h2, v[23:16], 2'h0, "pointer byte2");
        end
    endtask

    initial begin
        repeat (6) @(posedge CORE_CLK);
        RST_N <= 1'h1;
        rd(6'h16, 8'h00, 2'h0, "repeat reset");
        rd(6'h18, 8'h00, 2'h0, "source reset");
        rd(6'h2c, 8'h00, 2'h0, "dest reset");
        rd(6'h14, 8'h01, 2'h0, "count reset");
        rd(6'h17, 8'h00, 2'h2, "reserved");
        rd(6'h30, 8'h00, 2'h2, "above map");
        wr(6'h3f, 8'h5a, 2'h2);
        sa = $random(seed);
        wr(6'h26, sa[7:0], 2'h0);
        rd(6'h26, sa[7:0], 2'h0, "second block");
        wrp(6'h2c, $random(seed));
        wr(6'h00, 8'h80, 2'h0);
        // Each step code on both pointers, random block and repeat counts
        for (m = 0; m < 4; m = m + 1) begin
            nb = {$random(seed)} % 4 + 1;
            rp = {$random(seed)} % 3 + 1;
            sa = $random(seed);
            da = $random(seed);
            md = m[1:0] ^ 2'h1;
            slow <= m[0];
            wr(6'h01, (m == 3) ? 8'h00 : 8'h01, 2'h0);
            wrp(6'h18, sa);
            wrp(6'h1c, da);
            wr(6'h12, {2'h0, m[1:0], 2'h0, md}, 2'h0);
            wr(6'h14, nb[7:0], 2'h0);
            wr(6'h15, 8'h00, 2'h0);
            wr(6'h16, rp[7:0], 2'h0);
            b0 = nblk;
            wr(6'h10, 8'ha0, 2'h0);
            for (n = 0; n < 3000 && CH_ACTIVE[0]; n = n + 1)
                @(posedge CORE_CLK);
            repeat (4) @(posedge CORE_CLK);
            chk(CH_ACTIVE[0], 32'h0, "channel end");
            chk(nblk - b0, rp, "blocks done");
            chk(s0, moved(sa, m[1:0], nb * rp), "source end");
            chk(d0, moved(da, md, nb * rp), "dest end");
            rd(6'h16, 8'h00, 2'h0, "repeat left");
            rd(6'h03, 8'h01, 2'h0, "done flag");
            chk(IRQ, (m == 3) ? 32'h0 : 32'h1, "irq raised");
            wr(6'h03, 8'h01, 2'h0);
            repeat (2) @(posedge CORE_CLK);
            chk(IRQ, 32'h0, "irq cleared");
        end
        // Zero repeat count runs on; step mode stays locked while busy
        sa = $random(seed);
        wrp(6'h18, sa);
        wr(6'h12, 8'h10, 2'h0);
        wr(6'h14, 8'h02, 2'h0);
        wr(6'h15, 8'h00, 2'h0);
        wr(6'h16, 8'h00, 2'h0);
        b0 = nblk;
        r0 = nrd;
        wr(6'h10, 8'ha0, 2'h0);
        wr(6'h12, 8'h20, 2'h0);
        for (n = 0; n < 500 && nblk - b0 < 5; n = n + 1)
            @(posedge CORE_CLK);
        chk(CH_ACTIVE[0], 32'h1, "unlimited run");
        chk(nblk - b0 > 4, 32'h1, "unlimited blocks");
        wr(6'h10, 8'h00, 2'h0);
        repeat (4) @(posedge CORE_CLK);
        chk(s0, moved(sa, 2'h1, nrd - r0), "locked mode");
        // Bus error on the second channel raises and clears the interrupt
        wr(6'h01, 8'h20, 2'h0);
        wr(6'h24, 8'h02, 2'h0);
        wr(6'h26, 8'h00, 2'h0);
        wr(6'h20, 8'ha0, 2'h0);
        TRIGGER_REQ <= 2'h2;
        rd(6'h04, 8'h22, 2'h0, "channel state");
        BUS_ERR <= 2'h2;
        @(posedge CORE_CLK);
        BUS_ERR <= 2'h0;
        repeat (3) @(posedge CORE_CLK);
        chk(CH_ACTIVE[1], 32'h0, "error stop");
        chk(IRQ, 32'h1, "error irq");
        rd(6'h03, 8'h20, 2'h0, "error flag");
        wr(6'h03, 8'h20, 2'h0);
        repeat (2) @(posedge CORE_CLK);
        chk(IRQ, 32'h0, "error irq clear");
        test_done;
    end
endmodule // test_dma_channel_address_repeat
